// File: pkg/dac_ctrl_pkg.sv
// Constants for the two-instance converter control block.
// Assumes an Avalon-MM byte-addressed slave port and one core clock.
package dac_ctrl_pkg;

	localparam int          ADDR_W      = 14;
	localparam int          DATA_W      = 32;
	localparam int          LEVEL_W     = 8;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_A_CTRL  = 12'h88C;
	localparam logic [11:0] IDX_A_LEVEL = 12'h88D;
	localparam logic [11:0] IDX_B_CTRL  = 12'h890;
	localparam logic [11:0] IDX_B_LEVEL = 12'h891;

	// Control field positions
	localparam int          EN_BIT      = 7;
	localparam int          RANGE_BIT   = 6;
	localparam int          OE_HI       = 5;
	localparam int          OE_LO       = 4;
	localparam int          POS_REF_HI  = 3;
	localparam int          POS_REF_LO  = 2;
	localparam int          NEG_REF_BIT = 0;

	// Implemented bits per control register; others read zero
	localparam logic [7:0]  CTRL_A_MASK = 8'hFD;
	localparam logic [7:0]  CTRL_B_MASK = 8'h8D;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [7:0]  LEVEL_RESET = 8'h00;

	// Output-enable codes
	localparam logic [1:0]  OE_PIN_B    = 2'h2;
	localparam logic [1:0]  OE_PIN_A    = 2'h1;

	// Positive reference codes
	localparam logic [1:0]  POS_REF_SUPPLY = 2'h0;
	localparam logic [1:0]  POS_REF_PIN    = 2'h1;
	localparam logic [1:0]  POS_REF_FIXED  = 2'h2;

	// Bus handshake phases
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

endpackage

// File: verilog/dac_control_registers.sv
// Register file and control logic for two 8-bit converter instances.
// Assumes an Avalon-MM master on core_clk; config and sleep levels come
// from other domains and are synchronised here.
`timescale 1ns/1ns
module dac_control_registers
	import dac_ctrl_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic [ADDR_W-1:0]   address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [DATA_W-1:0]   writedata,
	input  wire logic [DATA_W/8-1:0] byteenable,
	output logic      [DATA_W-1:0]   readdata,
	output logic                     waitrequest,
	input  wire logic                auto_range_config,
	input  wire logic                sleep_mode,
	output logic                     conv_a_enable,
	output logic                     conv_a_ref_on,
	output logic      [1:0]          conv_a_pos_ref_select,
	output logic                     conv_a_neg_ref_select,
	output logic      [LEVEL_W-1:0]  conv_a_level_code,
	output logic                     conv_a_high_range,
	output logic                     buffered_out_a_en,
	output logic                     buffered_out_b_en,
	output logic                     conv_b_enable,
	output logic                     conv_b_ref_on,
	output logic      [1:0]          conv_b_pos_ref_select,
	output logic                     conv_b_neg_ref_select,
	output logic      [LEVEL_W-1:0]  conv_b_level_code
);

	////////////////////////////////////////////////////////////////////
	// Synchronisers for the configuration strap and sleep level

	logic       auto_meta;
	logic       auto_cfg;
	logic       sleep_meta;
	logic       sleep_now;

	// Two flops each; only the second flop is read by logic
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			auto_meta  <= 1'b0;
			auto_cfg   <= 1'b0;
			sleep_meta <= 1'b0;
			sleep_now  <= 1'b0;
		end else begin
			auto_meta  <= auto_range_config;
			auto_cfg   <= auto_meta;
			sleep_meta <= sleep_mode;
			sleep_now  <= sleep_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait cycle, then the access completes

	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic       request;
	logic       commit;

	assign request = read | write;
	// Access takes effect only at the edge that sees waitrequest low
	assign commit  = request & ~waitrequest;
	assign next_bus_state = (request && bus_state == BUS_IDLE) ? BUS_ACK : BUS_IDLE;

	// Waitrequest is held high except in the single answer cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			bus_state   <= BUS_IDLE;
			waitrequest <= 1'b1;
		end else begin
			bus_state   <= next_bus_state;
			waitrequest <= (next_bus_state != BUS_ACK);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Address decode

	logic hit_a_ctrl;
	logic hit_a_level;
	logic hit_b_ctrl;
	logic hit_b_level;
	logic lane0_wr;

	assign hit_a_ctrl  = (address == {IDX_A_CTRL, 2'b00});
	assign hit_a_level = (address == {IDX_A_LEVEL, 2'b00});
	assign hit_b_ctrl  = (address == {IDX_B_CTRL, 2'b00});
	assign hit_b_level = (address == {IDX_B_LEVEL, 2'b00});
	// Registers live in byte lane 0; other lanes are ignored
	assign lane0_wr    = commit & write & byteenable[0];

	////////////////////////////////////////////////////////////////////
	// Control and level registers

	logic [7:0]         ctrl_a;
	logic [7:0]         ctrl_b;
	logic [LEVEL_W-1:0] level_a;
	logic [LEVEL_W-1:0] level_b;

	// Only the device reset clears these; sleep and wake leave them alone
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_a  <= CTRL_RESET;
			ctrl_b  <= CTRL_RESET;
			level_a <= LEVEL_RESET;
			level_b <= LEVEL_RESET;
		end else begin
			if (lane0_wr && hit_a_ctrl)
				ctrl_a  <= writedata[7:0] & CTRL_A_MASK;
			if (lane0_wr && hit_b_ctrl)
				ctrl_b  <= writedata[7:0] & CTRL_B_MASK;
			if (lane0_wr && hit_a_level)
				level_a <= writedata[LEVEL_W-1:0];
			if (lane0_wr && hit_b_level)
				level_b <= writedata[LEVEL_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data; unmapped addresses read as zero

	logic [DATA_W-1:0] next_readdata;

	assign next_readdata =
		hit_a_ctrl  ? {{(DATA_W-8){1'b0}}, ctrl_a} :
		hit_a_level ? {{(DATA_W-LEVEL_W){1'b0}}, level_a} :
		hit_b_ctrl  ? {{(DATA_W-8){1'b0}}, ctrl_b} :
		hit_b_level ? {{(DATA_W-LEVEL_W){1'b0}}, level_b} :
		{DATA_W{1'b0}};

	// Loaded with the wait cycle so it stands when waitrequest drops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			readdata <= '0;
		else if (read && next_bus_state == BUS_ACK)
			readdata <= next_readdata;
	end

	////////////////////////////////////////////////////////////////////
	// Converter controls toward the analog macro

	logic [1:0] oe_code;
	logic       next_high_range;
	logic       next_out_a;
	logic       next_out_b;

	assign oe_code = ctrl_a[OE_HI:OE_LO];
	// Software range when the strap is one, else level MSB picks it
	assign next_high_range = auto_cfg ? ctrl_a[RANGE_BIT]
	                                  : level_a[LEVEL_W-1];
	// Codes 00 and 11 leave both pins undriven
	assign next_out_a = (oe_code == OE_PIN_A);
	assign next_out_b = (oe_code == OE_PIN_B);

	// Level and reference selects go straight to the ladder, which spans
	// two-to-the-n steps between the chosen references; reserved
	// positive code 11 is passed through untouched.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			conv_a_enable         <= 1'b0;
			conv_a_ref_on         <= 1'b0;
			conv_a_pos_ref_select <= POS_REF_SUPPLY;
			conv_a_neg_ref_select <= 1'b0;
			conv_a_level_code     <= LEVEL_RESET;
			conv_a_high_range     <= 1'b0;
			buffered_out_a_en     <= 1'b0;
			buffered_out_b_en     <= 1'b0;
		end else begin
			conv_a_enable         <= ctrl_a[EN_BIT];
			conv_a_ref_on         <= ctrl_a[EN_BIT] & ~sleep_now;
			conv_a_pos_ref_select <= ctrl_a[POS_REF_HI:POS_REF_LO];
			conv_a_neg_ref_select <= ctrl_a[NEG_REF_BIT];
			conv_a_level_code     <= level_a;
			conv_a_high_range     <= next_high_range;
			buffered_out_a_en     <= next_out_a;
			buffered_out_b_en     <= next_out_b;
		end
	end

	// Second instance: no buffer, no pins, internal consumers only
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			conv_b_enable         <= 1'b0;
			conv_b_ref_on         <= 1'b0;
			conv_b_pos_ref_select <= POS_REF_SUPPLY;
			conv_b_neg_ref_select <= 1'b0;
			conv_b_level_code     <= LEVEL_RESET;
		end else begin
			conv_b_enable         <= ctrl_b[EN_BIT];
			conv_b_ref_on         <= ctrl_b[EN_BIT] & ~sleep_now;
			conv_b_pos_ref_select <= ctrl_b[POS_REF_HI:POS_REF_LO];
			conv_b_neg_ref_select <= ctrl_b[NEG_REF_BIT];
			conv_b_level_code     <= level_b;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	logic wr_a_ctrl;
	logic wr_a_level;
	logic wr_b_ctrl;
	logic wr_b_level;
	assign wr_a_ctrl  = lane0_wr & hit_a_ctrl;
	assign wr_a_level = lane0_wr & hit_a_level;
	assign wr_b_ctrl  = lane0_wr & hit_b_ctrl;
	assign wr_b_level = lane0_wr & hit_b_level;

	sequence req_waiting;
		request && waitrequest && bus_state == BUS_IDLE;
	endsequence

	sequence one_wait_then_ack;
		!waitrequest ##1 waitrequest;
	endsequence

	bus_answer_a: assert property (req_waiting |=> one_wait_then_ack)
		else $error("bus answer not after exactly one wait cycle");

	enable_write_a: assert property (
		wr_a_ctrl |-> ##2 conv_a_enable == $past(writedata[EN_BIT], 2))
		else $error("enable does not follow control write");

	sw_range_a: assert property (
		(auto_cfg && wr_a_ctrl && !wr_a_level) ##1 auto_cfg
		|=> conv_a_high_range == $past(writedata[RANGE_BIT], 2))
		else $error("software range not applied");

	hw_range_a: assert property (
		(!auto_cfg && wr_a_level) ##1 !auto_cfg
		|=> conv_a_high_range == $past(writedata[LEVEL_W-1], 2))
		else $error("automatic range not taken from level MSB");

	pin_enable_a: assert property (
		wr_a_ctrl |-> ##2 (buffered_out_a_en == ($past(writedata[OE_HI:OE_LO], 2) == OE_PIN_A))
		&& (buffered_out_b_en == ($past(writedata[OE_HI:OE_LO], 2) == OE_PIN_B)))
		else $error("pin enables mismatch output-enable code");

	pos_ref_b_a: assert property (
		wr_b_ctrl |-> ##2 conv_b_pos_ref_select == $past(writedata[POS_REF_HI:POS_REF_LO], 2))
		else $error("positive reference select wrong");

	sleep_ref_a: assert property (
		sleep_now [*2] |-> !conv_a_ref_on && !conv_b_ref_on)
		else $error("reference active during sleep");

	inst_b_bits_a: assert property (
		(ctrl_b & ~CTRL_B_MASK) == 8'h00)
		else $error("unimplemented bits set in second instance");

	level_hold_a: assert property (
		wr_a_level |-> ##2 conv_a_level_code == $past(writedata[LEVEL_W-1:0], 2))
		else $error("level code not written");

	sleep_keep_a: assert property (
		$rose(sleep_now) && !lane0_wr |=> $stable(ctrl_a) && $stable(level_a))
		else $error("registers changed on sleep entry");

	// Field checks for the remaining control bits of both instances and the second level code
	pos_ref_a_a: assert property (
		wr_a_ctrl |-> ##2 conv_a_pos_ref_select == $past(writedata[POS_REF_HI:POS_REF_LO], 2))
		else $error("first positive reference select wrong");

	neg_ref_a_a: assert property (
		wr_a_ctrl |-> ##2 conv_a_neg_ref_select == $past(writedata[NEG_REF_BIT], 2))
		else $error("first negative reference select wrong");

	neg_ref_b_a: assert property (
		wr_b_ctrl |-> ##2 conv_b_neg_ref_select == $past(writedata[NEG_REF_BIT], 2))
		else $error("second negative reference select wrong");

	enable_b_a: assert property (
		wr_b_ctrl |-> ##2 conv_b_enable == $past(writedata[EN_BIT], 2))
		else $error("second enable does not follow control write");

	level_b_a: assert property (
		wr_b_level |-> ##2 conv_b_level_code == $past(writedata[LEVEL_W-1:0], 2))
		else $error("second level code not written");

	// A single-pin code can never light both buffered pins at once
	pins_exclusive_a: assert property (
		!(buffered_out_a_en && buffered_out_b_en))
		else $error("both buffered pins driven");

	// Refused writes and read data framing
	lane_off_a: assert property (
		commit && write && !byteenable[0]
		|=> $stable(ctrl_a) && $stable(level_a) && $stable(ctrl_b) && $stable(level_b))
		else $error("write with lane 0 disabled changed a register");

	read_upper_a: assert property (
		readdata[DATA_W-1:8] == '0)
		else $error("upper read data bits not zero");

	read_level_a: assert property (
		commit && read && hit_a_level |-> readdata == {{(DATA_W-LEVEL_W){1'b0}}, level_a})
		else $error("read data does not match level register");

	// Enables lag their register by exactly one flop, sleep or not
	enable_follow_a: assert property (
		conv_a_enable == $past(ctrl_a[EN_BIT]) && conv_b_enable == $past(ctrl_b[EN_BIT]))
		else $error("enable output not registered from control bit");

endmodule

// File: sim/dac_control_registers_tb.sv
// Self-checking bench for the two-instance converter control block.
// Assumes the block answers Avalon-MM with waitrequest on one core clock.
`timescale 1ns/1ns
module dac_control_registers_tb
	import dac_ctrl_pkg::*;
;
	localparam logic [ADDR_W-1:0] A_CTRL  = {IDX_A_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] A_LEVEL = {IDX_A_LEVEL, 2'h0};
	localparam logic [ADDR_W-1:0] B_CTRL  = {IDX_B_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] B_LEVEL = {IDX_B_LEVEL, 2'h0};
	localparam logic [ADDR_W-1:0] UNUSED  = 14'h2238;

	logic                core_clk          = 1'h0;
	logic                reset             = 1'h1;
	logic [ADDR_W-1:0]   address           = '0;
	logic                read              = 1'h0;
	logic                write             = 1'h0;
	logic [DATA_W-1:0]   writedata         = '0;
	logic [DATA_W/8-1:0] byteenable        = '0;
	logic                auto_range_config = 1'h0;
	logic                sleep_mode        = 1'h0;
	logic [DATA_W-1:0]   readdata;
	logic                waitrequest;
	logic                conv_a_enable, conv_a_ref_on, conv_a_neg_ref_select, conv_a_high_range;
	logic                buffered_out_a_en, buffered_out_b_en;
	logic                conv_b_enable, conv_b_ref_on, conv_b_neg_ref_select;
	logic [1:0]          conv_a_pos_ref_select, conv_b_pos_ref_select;
	logic [LEVEL_W-1:0]  conv_a_level_code, conv_b_level_code;
	// Expected register contents and strap levels
	logic [7:0]          ma_c = 8'h00, ma_l = 8'h00, mb_c = 8'h00, mb_l = 8'h00;
	logic                cfg  = 1'h0, slp = 1'h0;
	logic [7:0]          vals [5] = '{8'h81, 8'h94, 8'hA8, 8'hFF, 8'h42};
	int                  err_count = 0, samples_checked = 0;

	always #2 core_clk = ~core_clk;

	dac_control_registers i_dac_control_registers (.core_clk(core_clk), .reset(reset),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.auto_range_config(auto_range_config), .sleep_mode(sleep_mode),
		.conv_a_enable(conv_a_enable), .conv_a_ref_on(conv_a_ref_on),
		.conv_a_pos_ref_select(conv_a_pos_ref_select),
		.conv_a_neg_ref_select(conv_a_neg_ref_select), .conv_a_level_code(conv_a_level_code),
		.conv_a_high_range(conv_a_high_range), .buffered_out_a_en(buffered_out_a_en),
		.buffered_out_b_en(buffered_out_b_en), .conv_b_enable(conv_b_enable),
		.conv_b_ref_on(conv_b_ref_on), .conv_b_pos_ref_select(conv_b_pos_ref_select),
		.conv_b_neg_ref_select(conv_b_neg_ref_select), .conv_b_level_code(conv_b_level_code));

	////////////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task print_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycle: request held until waitrequest is sampled low, bounded wait
	task bus(input logic rd_n, input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [7:0] q);
		int n;
		@(posedge core_clk);
		address    <= a;
		writedata  <= {24'h000000, d};
		byteenable <= be;
		read       <= rd_n;
		write      <= !rd_n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 50);
		q = readdata[7:0];
		if (n >= 50)
			chk("waitrequest", 8'h00, {7'h00, waitrequest});
		read  <= 1'h0;
		write <= 1'h0;
	endtask

	// Write and track the expected register image
	task wm(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'h0, a, d, 4'hF, q);
		if (a == A_CTRL) ma_c = d & CTRL_A_MASK;
		if (a == A_LEVEL) ma_l = d;
		if (a == B_CTRL) mb_c = d & CTRL_B_MASK;
		if (a == B_LEVEL) mb_l = d;
	endtask

	task rd(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'h1, a, 8'h00, 4'hF, q);
		chk(name, exp, q);
		chk("readdata_upper", 8'h00, {7'h00, |readdata[DATA_W-1:8]});
	endtask

	// Outputs toward the analog macro, after the flops have settled
	task check_all;
		logic [7:0] ea;
		// Settling wait after every level change before anything is judged
		repeat (4) @(posedge core_clk);
		ea = {ma_c[7], ma_c[7] & !slp, ma_c[3:2], ma_c[0], cfg ? ma_c[6] : ma_l[7],
			ma_c[5:4] == 2'h1, ma_c[5:4] == 2'h2};
		chk("conv_a", ea, {conv_a_enable, conv_a_ref_on, conv_a_pos_ref_select,
			conv_a_neg_ref_select, conv_a_high_range, buffered_out_a_en, buffered_out_b_en});
		chk("conv_a_level_code", ma_l, conv_a_level_code);
		chk("conv_b", {mb_c[7], mb_c[7] & !slp, mb_c[3:2], mb_c[0], 3'h0}, {conv_b_enable,
			conv_b_ref_on, conv_b_pos_ref_select, conv_b_neg_ref_select, 3'h0});
		chk("conv_b_level_code", mb_l, conv_b_level_code);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the roughly 300 cycles the tests need
	initial begin
		repeat (20000) @(posedge core_clk);
		chk("watchdog", 8'h00, 8'hFF);
		print_verdict();
	end

	// Main sequence
	initial begin
		logic [7:0] q;
		repeat (20) @(posedge core_clk);
		reset <= 1'h0;
		repeat (3) @(posedge core_clk);
		check_all();
		rd("a_ctrl", A_CTRL, CTRL_RESET);
		rd("a_level", A_LEVEL, LEVEL_RESET);
		rd("b_ctrl", B_CTRL, CTRL_RESET);
		rd("b_level", B_LEVEL, LEVEL_RESET);
		// Every output, reference and range code, both ranging modes
		for (int c = 0; c < 2; c++) begin
			cfg = c[0];
			auto_range_config <= cfg;
			for (int i = 0; i < 5; i++) begin
				wm(A_CTRL, vals[i]);
				wm(A_LEVEL, vals[i]);
				wm(B_CTRL, vals[i]);
				wm(B_LEVEL, ~vals[i]);
				check_all();
				rd("a_ctrl", A_CTRL, vals[i] & 8'hFD);
				rd("b_ctrl", B_CTRL, vals[i] & 8'h8D);
			end
		end
		// Lane disabled and unmapped place are both ignored
		bus(1'h0, A_LEVEL, 8'h5A, 4'h0, q);
		rd("a_level", A_LEVEL, ma_l);
		wm(UNUSED, 8'hA5);
		rd("unmapped", UNUSED, 8'h00);
		// Sleep gates only the reference, registers survive wake
		wm(A_CTRL, 8'h81);
		wm(B_CTRL, 8'h8D);
		slp = 1'h1;
		sleep_mode <= 1'h1;
		check_all();
		slp = 1'h0;
		sleep_mode <= 1'h0;
		check_all();
		rd("a_ctrl", A_CTRL, 8'h81);
		rd("b_level", B_LEVEL, mb_l);
		// Reset in mid-run clears everything
		reset <= 1'h1;
		repeat (2) @(posedge core_clk);
		reset <= 1'h0;
		ma_c = 8'h00;
		ma_l = 8'h00;
		mb_c = 8'h00;
		mb_l = 8'h00;
		repeat (3) @(posedge core_clk);
		check_all();
		rd("a_level", A_LEVEL, 8'h00);
		print_verdict();
	end
endmodule
